// ===== bench/adc_result_dac_code_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_result_dac_code_regs_tb;
    logic        clock = 1'b0, srst = 1'b1, wide_variant = 1'b1, v;
    logic        third_analog_input_valid = 1'b0, fourth_analog_input_valid = 1'b0;
    logic [9:0]  third_analog_input = 10'h000, fourth_analog_input = 10'h000;
    wire  logic  write_en, read_en, read_valid;
    wire  logic [7:0]  address, write_data, read_data;
    wire  logic [11:0] output_voltage_a, output_voltage_b, output_voltage_c, output_voltage_d;
    wire  logic [47:0] outs = {output_voltage_d, output_voltage_c, output_voltage_b,
                               output_voltage_a};
    logic [7:0]  d, hi, lo, km;
    int          err_count = 0, tests_run = 0, cycles = 0;
    host_model host_model_i (.*);
    adc_result_dac_code_regs adc_result_dac_code_regs_i (.*);
    always #5 clock = ~clock;
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_model_i.rd(a, d, v);
        chk("read_valid", 12'h001, {11'h000, v});
        chk("read_data", {4'h0, e}, {4'h0, d});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, far above the roughly 140 cycles needed
    always @(posedge clock) if (++cycles == 5000) begin
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(25676));
        repeat (8) @(negedge clock);
        srst = 1'b0;
        for (int i = 0; i < 10; i++) rchk(8'(i < 2 ? 8'h0a + i : 8'h0e + i), 8'h00);
        // result pulse ends as the read is raised, half a cycle before it is taken
        {third_analog_input, fourth_analog_input} = 20'($urandom);
        third_analog_input_valid = 1'b1;
        third_analog_input_valid <= #10 1'b0;
        rchk(8'h0a, third_analog_input[9:2]);
        host_model_i.wr(8'h0a, ~third_analog_input[9:2]);
        rchk(8'h0a, third_analog_input[9:2]);
        fourth_analog_input_valid = 1'b1;
        fourth_analog_input_valid <= #10 1'b0;
        rchk(8'h0b, fourth_analog_input[9:2]);
        // high first, then a quiet gap so each write is seen alone
        for (int w = 1; w >= 0; w--) begin
            wide_variant = w[0];
            for (int k = 0; k < 4; k++) begin
                {hi, lo} = 16'($urandom);
                if (k == 0) lo = 8'hff;
                host_model_i.wr(8'(8'h11 + 2 * k), hi);
                repeat (2) @(negedge clock);
                host_model_i.wr(8'(8'h10 + 2 * k), lo);
                km = lo & (w[0] ? 8'hf0 : 8'hc0);
                rchk(8'(8'h10 + 2 * k), km);
                rchk(8'(8'h11 + 2 * k), hi);
                chk("output_voltage", {hi, km[7:4]}, outs[12 * k +: 12]);
            end
        end
        host_model_i.wr(8'h19, 8'h80);
        repeat (3) @(negedge clock);
        for (int k = 0; k < 4; k++) chk("output_voltage", 12'h000, outs[12 * k +: 12]);
        rchk(8'h17, 8'h00);
        rchk(8'h0a, 8'h00);
        // a mid-run reset must clear a live code, not one already zero
        host_model_i.wr(8'h15, 8'ha5);
        repeat (3) @(negedge clock);
        chk("output_voltage_c", 12'ha50, output_voltage_c);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        chk("output_voltage_c", 12'h000, output_voltage_c);
        rchk(8'h15, 8'h00);
        rchk(8'h30, 8'h00);
        report_and_stop();
    end
endmodule // adc_result_dac_code_regs_tb
`default_nettype wire

// ===== bench/code_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// sees only the bank's ports
module code_regs_assertions (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        wide_variant,
    input  wire logic        write_en,
    input  wire logic        read_en,
    input  wire logic        read_valid,
    input  wire logic        third_analog_input_valid,
    input  wire logic        fourth_analog_input_valid,
    input  wire logic [7:0]  address,
    input  wire logic [7:0]  write_data,
    input  wire logic [7:0]  read_data,
    input  wire logic [9:0]  third_analog_input,
    input  wire logic [9:0]  fourth_analog_input,
    input  wire logic [11:0] output_voltage_a,
    input  wire logic [11:0] output_voltage_b,
    input  wire logic [11:0] output_voltage_c,
    input  wire logic [11:0] output_voltage_d
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // no later write may overtake the one under test
    sequence quiet2; !write_en [*2]; endsequence
    sequence rd_at(a); read_en && !write_en && address == a; endsequence
    // no write just before, so no soft clear can swallow this one
    sequence lone_wr(a); !write_en ##1 write_en && address == a; endsequence
    a_third_res: assert property (third_analog_input_valid ##1 rd_at(8'h0a)
        |=> read_data == $past(third_analog_input[9:2], 2)) else $error("bad 0x0a read");
    a_fourth_res: assert property (fourth_analog_input_valid ##1 rd_at(8'h0b)
        |=> read_data == $past(fourth_analog_input[9:2], 2)) else $error("bad 0x0b read");
    a_reset_zero: assert property (disable iff (1'b0) srst
        |=> read_data == 8'h00 && !read_valid && output_voltage_a == 12'h000) else $error("not reset");
    a_high_out: assert property (lone_wr(8'h11) ##1 quiet2
        |=> output_voltage_a[11:4] == $past(write_data, 3)) else $error("bad a output");
    a_low_out: assert property (lone_wr(8'h14) ##1 quiet2
        |=> output_voltage_c[3:0] == ($past(write_data, 3) & ($past(wide_variant, 3)
        ? 8'hf0 : 8'hc0)) >> 4) else $error("bad c output");
    a_d_out: assert property (lone_wr(8'h17) ##1 quiet2
        |=> output_voltage_d[11:4] == $past(write_data, 3)) else $error("bad d output");
    a_low_back: assert property (lone_wr(8'h10) ##1 !write_en ##1 rd_at(8'h10)
        |=> read_data == ($past(write_data, 3) & ($past(wide_variant, 3) ? 8'hf0 : 8'hc0)))
        else $error("bad low readback");
    a_soft_clear: assert property (write_en && address == 8'h19 && write_data[7]
        ##1 !write_en [*3] |=> (output_voltage_a | output_voltage_b | output_voltage_c
        | output_voltage_d) == 12'h000) else $error("outputs not cleared");
endmodule // code_regs_assertions
bind adc_result_dac_code_regs code_regs_assertions code_regs_assertions_i (.*);
`default_nettype wire

// ===== bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the register port; released lines show the inverse, never a stale copy
module host_model (
    input  wire logic       clock,
    input  wire logic       read_valid,
    input  wire logic [7:0] read_data,
    output var  logic       write_en = 1'b0,
    output var  logic       read_en = 1'b0,
    output var  logic [7:0] address = 8'h00,
    output var  logic [7:0] write_data = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(negedge clock);
        {write_en, address, write_data} = {1'b1, a, dt};
        @(negedge clock);
        {write_en, address, write_data} = {1'b0, ~a, ~dt};
    endtask
    // answer stands from the taking edge and is sampled half a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] dt, output logic v);
        @(negedge clock);
        {read_en, address} = {1'b1, a};
        @(negedge clock);
        {read_en, address} = {1'b0, ~a};
        {v, dt} = {read_valid, read_data};
    endtask
endmodule // host_model
`default_nettype wire

// ===== src/adc_result_dac_code_regs.sv
// Contract
// - address 0x0a reads top eight bits of third input result.
// - address 0x0b reads top eight bits of fourth input result.
// - result bytes read-only, result bit 9 in d7, zero after reset.
// - 0x10 low code: d7:d4 wide variant, d7:d6 narrow variant.
// - 0x11 high code holds top eight bits, joined with low code.
// - 0x12/0x13 hold channel b code, drives output b.
// - 0x14/0x15 hold channel c code, drives output c.
// - 0x16/0x17 hold channel d code, drives output d.
// - code registers read/write, reset to zero giving 0 V outputs.
// - soft reset bit in second config register clears results, codes and outputs.
`timescale 1ns/1ps
`default_nettype none
module adc_result_dac_code_regs (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        wide_variant,
    input  wire logic        write_en,
    input  wire logic        read_en,
    input  wire logic [7:0]  address,
    input  wire logic [7:0]  write_data,
    input  wire logic [9:0]  third_analog_input,
    input  wire logic        third_analog_input_valid,
    input  wire logic [9:0]  fourth_analog_input,
    input  wire logic        fourth_analog_input_valid,
    output var  logic [7:0]  read_data,
    output var  logic        read_valid,
    output var  logic [11:0] output_voltage_a,
    output var  logic [11:0] output_voltage_b,
    output var  logic [11:0] output_voltage_c,
    output var  logic [11:0] output_voltage_d
);
    logic [7:0]  third_high_q;
    logic [7:0]  fourth_high_q;
    logic        soft_reset_q;
    logic [3:0]  write_low;
    logic [3:0]  write_high;
    logic [7:0]  low_q   [4];
    logic [7:0]  high_q  [4];
    logic [11:0] code_q  [4];
    logic [7:0]  read_mux;

    // channel index from an address in 0x10..0x17
    function automatic logic [1:0] chan_of(input logic [7:0] addr);
        chan_of = addr[2:1];
    endfunction

    // the soft reset is a one-cycle pulse; the bit itself self-clears
    always_ff @(posedge clock) begin
        if (srst) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= write_en && address == code_regs_pkg::config_two_addr
                            && write_data[code_regs_pkg::soft_reset_bit];
        end
    end

    // result bytes are loaded by the converter, never by the host
    always_ff @(posedge clock) begin
        if (srst || soft_reset_q) begin
            third_high_q <= code_regs_pkg::reg_reset_value;
        end else if (third_analog_input_valid) begin
            third_high_q <= third_analog_input[9:2];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || soft_reset_q) begin
            fourth_high_q <= code_regs_pkg::reg_reset_value;
        end else if (fourth_analog_input_valid) begin
            fourth_high_q <= fourth_analog_input[9:2];
        end
    end

    // write strobes per channel; even address is low byte, odd is high
    always_comb begin
        write_low  = 4'h0;
        write_high = 4'h0;
        if (write_en && address[7:3] == code_regs_pkg::channel_a_code_low_addr[7:3]) begin
            if (address[0]) begin
                write_high[chan_of(address)] = 1'b1;
            end else begin
                write_low[chan_of(address)] = 1'b1;
            end
        end
    end

    for (genvar i = 0; i < code_regs_pkg::channel_count; i++) begin : g_chan
        code_channel u_chan (
            .clock      (clock),
            .srst       (srst),
            .clear      (soft_reset_q),
            .wide       (wide_variant),
            .write_low  (write_low[i]),
            .write_high (write_high[i]),
            .write_data (write_data),
            .low_q      (low_q[i]),
            .high_q     (high_q[i]),
            .code_q     (code_q[i])
        );
    end

    // read decode; result writes are ignored, unmapped reads give zero
    always_comb begin
        read_mux = 8'h00;
        case (address)
            code_regs_pkg::third_input_result_high_addr:  read_mux = third_high_q;
            code_regs_pkg::fourth_input_result_high_addr: read_mux = fourth_high_q;
            code_regs_pkg::channel_a_code_low_addr,
            code_regs_pkg::channel_b_code_low_addr,
            code_regs_pkg::channel_c_code_low_addr,
            code_regs_pkg::channel_d_code_low_addr:  read_mux = low_q[chan_of(address)];
            code_regs_pkg::channel_a_code_high_addr,
            code_regs_pkg::channel_b_code_high_addr,
            code_regs_pkg::channel_c_code_high_addr,
            code_regs_pkg::channel_d_code_high_addr: read_mux = high_q[chan_of(address)];
            default: read_mux = 8'h00;
        endcase
    end

    // registered read answer, one cycle after read_en
    always_ff @(posedge clock) begin
        if (srst) begin
            read_data  <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= read_en;
            if (read_en) begin
                read_data <= read_mux;
            end
        end
    end

    // output codes straight from the channel flops, one more stage keeps outputs registered
    always_ff @(posedge clock) begin
        if (srst) begin
            output_voltage_a <= 12'h000;
            output_voltage_b <= 12'h000;
            output_voltage_c <= 12'h000;
            output_voltage_d <= 12'h000;
        end else begin
            output_voltage_a <= code_q[0];
            output_voltage_b <= code_q[1];
            output_voltage_c <= code_q[2];
            output_voltage_d <= code_q[3];
        end
    end
endmodule // adc_result_dac_code_regs
`default_nettype wire

// ===== src/code_channel.sv
`timescale 1ns/1ps
`default_nettype none
// one dac channel: low and high code bytes plus the assembled code
module code_channel (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clear,
    input  wire logic        wide,
    input  wire logic        write_low,
    input  wire logic        write_high,
    input  wire logic [7:0]  write_data,
    output var  logic [7:0]  low_q,
    output var  logic [7:0]  high_q,
    output var  logic [11:0] code_q
);
    logic [7:0] mask;

    // unused low bits never store, so they read back zero
    assign mask = wide ? code_regs_pkg::low_mask_wide : code_regs_pkg::low_mask_narrow;

    // low code byte
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            low_q <= code_regs_pkg::reg_reset_value;
        end else if (write_low) begin
            low_q <= write_data & mask;
        end
    end

    // high code byte
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            high_q <= code_regs_pkg::reg_reset_value;
        end else if (write_high) begin
            high_q <= write_data;
        end
    end

    // output code, left-aligned; narrow variant has zeros in its two lsbs
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            code_q <= 12'h000;
        end else begin
            code_q <= {high_q, low_q[7:4]};
        end
    end
endmodule // code_channel
`default_nettype wire

// ===== src/code_regs_pkg.sv
`default_nettype none
package code_regs_pkg;
    // register addresses
    localparam logic [7:0] third_input_result_high_addr  = 8'h0a;
    localparam logic [7:0] fourth_input_result_high_addr = 8'h0b;
    localparam logic [7:0] channel_a_code_low_addr       = 8'h10;
    localparam logic [7:0] channel_a_code_high_addr      = 8'h11;
    localparam logic [7:0] channel_b_code_low_addr       = 8'h12;
    localparam logic [7:0] channel_b_code_high_addr      = 8'h13;
    localparam logic [7:0] channel_c_code_low_addr       = 8'h14;
    localparam logic [7:0] channel_c_code_high_addr      = 8'h15;
    localparam logic [7:0] channel_d_code_low_addr       = 8'h16;
    localparam logic [7:0] channel_d_code_high_addr      = 8'h17;
    localparam logic [7:0] config_two_addr               = 8'h19;
    // reset values and fields
    localparam logic [7:0] reg_reset_value  = 8'h00;
    localparam int         soft_reset_bit   = 7;
    localparam int         channel_count    = 4;
    // low-code masks: 12-bit variant keeps d7:d4, 10-bit keeps d7:d6
    localparam logic [7:0] low_mask_wide    = 8'hf0;
    localparam logic [7:0] low_mask_narrow  = 8'hc0;
    localparam int         code_width       = 12;
endpackage
`default_nettype wire
